// >>> logic/dds_control_pin_router.sv
// per-channel routing of the synthesis-chip control pins and shared bnc b/c ports
`timescale 1ns/1ps
`default_nettype none
`include "dds_router_defs.svh"

// Overview of operation
// - top two bits pick write, set, clear or toggle of lower bits
// - bnc b and c configs at own addresses, channel zero only
// - bnc b and c configs share bnc a field layout and meaning
// - every channel has its own copy of each routing register
// - mode 000, the reset value, passes processor output straight to pin
// - mode 001 holds the pin low
// - mode 010 drives the pin from the selected event line
// - mode 011 drives processor AND selected line
// - mode 100 drives processor OR selected line
// - invert bit inverts result of direct, low and selector modes
// - invert bit in and/or modes inverts only the selected line
// - selector picks one of event bus lines 0 to 31
// - layout: mode 11:9, invert 8, zeros 7:5, selector 4:0
// - selector 5 is the live bnc a input level
// - update, ramp direction and ramp hold pins route like keying
// - keying router decoded at its own address
// - bnc direction 1 output, 0 input; invert affects both
// - bnc config writes from channel one are dropped silently
module dds_control_pin_router
  import dds_router_pkg::*;
#(
  parameter int NUM_CH = 2
)
(
  // clock and reset
  input  wire logic                                   clk_in,
  input  wire logic                                   reset_n_in,
  input  wire logic                                   ce_in,
  // register writes, one port per command processor
  input  wire dds_router_pkg::reg_write_type [NUM_CH-1:0] wr_in,
  // command processor pin levels and routing sources
  input  wire logic [NUM_CH-1:0][`PIN_COUNT-1:0]      dcp_pin_in,
  input  wire logic [`EVENT_LINES-1:0]                event_bus_in,
  input  wire logic                                   bnc_a_level_in,
  input  wire logic [`BNC_SRC_LINES-1:0]              bnc_source_in,
  // bnc b and c pins
  input  wire logic [`BNC_PORTS-1:0]                  bnc_pin_in,
  output var  logic [`BNC_PORTS-1:0]                  bnc_pin_out,
  output var  logic [`BNC_PORTS-1:0]                  bnc_pin_oe_n_out,
  output var  logic [`BNC_PORTS-1:0]                  bnc_level_out,
  // synthesis-chip control pins
  output var  logic [NUM_CH-1:0][`PIN_COUNT-1:0]      dds_pin_out
);

  // ========================================================================
  // helpers

  // address of the routing register for a pin; keying sits at its own offset
  function automatic logic [`REG_ADDR_W-1:0] route_addr(input int pin);
    logic [`REG_ADDR_W-1:0] a;
    a = `ADDR_UPDATE_ROUTE;
    unique case (pin)
      `PIN_UPDATE:    a = `ADDR_UPDATE_ROUTE;
      `PIN_KEYING:    a = `ADDR_KEYING_ROUTE;
      `PIN_RAMP_DIR:  a = `ADDR_RAMP_DIR_ROUTE;
      `PIN_RAMP_HOLD: a = `ADDR_RAMP_HOLD_ROUTE;
      default:        a = `ADDR_UPDATE_ROUTE;
    endcase
    return a;
  endfunction

  // pin value from one routing register
  function automatic logic route_value
  (
    input logic [`ROUTE_CFG_W-1:0]  cfg,
    input logic                     dcp,
    input logic [`EVENT_LINES-1:0]  bus
  );
    logic             invert_bit;
    logic             sel;
    logic             val;
    routing_mode_type mode;
    invert_bit  = cfg[`RT_INV_BIT];
    sel  = bus[cfg[`RT_SRC_HI:`RT_SRC_LO]];
    mode = routing_mode_type'(cfg[`RT_MODE_HI:`RT_MODE_LO]);
    unique case (mode)
      MODE_DIRECT:    val = dcp ^ invert_bit;
      MODE_FORCE_LOW: val = 1'b0 ^ invert_bit;
      MODE_SELECT:    val = sel ^ invert_bit;
      MODE_AND:       val = dcp & (sel ^ invert_bit);
      MODE_OR:        val = dcp | (sel ^ invert_bit);
      default:        val = dcp ^ invert_bit;
    endcase
    return val;
  endfunction

  // ========================================================================
  // selector view of the event bus

  logic [`EVENT_LINES-1:0] bus_view;

  // line 5 carries the live bnc a level so an input can gate a pin directly
  always_comb
  begin
    bus_view                = event_bus_in;
    bus_view[`RT_BNC_A_SRC] = bnc_a_level_in;
  end

  // ========================================================================
  // per-channel routing registers and registered pins

  logic [NUM_CH-1:0][`PIN_COUNT-1:0] pin_q;

  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
      for (genvar p = 0; p < `PIN_COUNT; p++)
      begin : g_pin
        logic [`ROUTE_CFG_W-1:0] cfg_q;
        logic [`PAYLOAD_W-1:0]   cfg_next;
        logic                    hit;

        assign hit      = wr_in[c].valid && (wr_in[c].addr == route_addr(p));
        assign cfg_next = apply_write({{(`PAYLOAD_W-`ROUTE_CFG_W){1'b0}}, cfg_q},
                                      wr_in[c].data, `RT_MASK);

        // one register per channel and pin, written only by that channel
        always_ff @(posedge clk_in or negedge reset_n_in)
        begin
          if (!reset_n_in)
            cfg_q <= `RT_RESET;
          else if (ce_in && hit)
            cfg_q <= cfg_next[`ROUTE_CFG_W-1:0];
        end

        // registered so a reconfiguration never glitches the chip pin
        always_ff @(posedge clk_in or negedge reset_n_in)
        begin
          if (!reset_n_in)
            pin_q[c][p] <= 1'b0;
          else if (ce_in)
            pin_q[c][p] <= route_value(cfg_q, dcp_pin_in[c][p], bus_view);
        end
      end
    end
  endgenerate

  assign dds_pin_out = pin_q;

  // ========================================================================
  // shared bnc b and c ports

  logic [`BNC_PORTS-1:0]  bnc_sync;
  reg_write_type          owner_wr;

  level_sync #(
    .WIDTH (`BNC_PORTS)
  ) u_bnc_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .async_in   (bnc_pin_in),
    .sync_out   (bnc_sync)
  );

  // only channel zero reaches the shared ports; other channels are dropped
  assign owner_wr = wr_in[`BNC_OWNER_CH];

  generate
    for (genvar b = 0; b < `BNC_PORTS; b++)
    begin : g_bnc
      bnc_port_cell #(
        .CFG_ADDR (`ADDR_BNC_B + `REG_ADDR_W'(b))
      ) u_bnc (
        .clk_in       (clk_in),
        .reset_n_in   (reset_n_in),
        .ce_in        (ce_in),
        .wr_in        (owner_wr),
        .source_in    (bnc_source_in),
        .pin_level_in (bnc_sync[b]),
        .pin_out      (bnc_pin_out[b]),
        .pin_oe_n_out (bnc_pin_oe_n_out[b]),
        .level_out    (bnc_level_out[b])
      );
    end
  endgenerate

endmodule

`default_nettype wire

// >>> inc/dds_router_defs.svh
// shared offsets, field positions, reset values and widths for the pin router
`ifndef DDS_ROUTER_DEFS_SVH
`define DDS_ROUTER_DEFS_SVH

// ==========================================================================
// register port
`define REG_ADDR_W        12
`define REG_DATA_W        32
`define PAYLOAD_W         30
`define WAM_HI            31
`define WAM_LO            30
`define WAM_WRITE         2'h0
`define WAM_SET           2'h1
`define WAM_CLEAR         2'h2
`define WAM_TOGGLE        2'h3

// ==========================================================================
// register offsets
`define ADDR_BNC_B            12'h081
`define ADDR_BNC_C            12'h082
`define ADDR_UPDATE_ROUTE     12'h084
`define ADDR_KEYING_ROUTE     12'h085
`define ADDR_RAMP_DIR_ROUTE   12'h086
`define ADDR_RAMP_HOLD_ROUTE  12'h087

// ==========================================================================
// routing register layout
`define ROUTE_CFG_W       12
`define RT_MODE_HI        11
`define RT_MODE_LO        9
`define RT_INV_BIT        8
`define RT_SRC_HI         4
`define RT_SRC_LO         0
`define RT_MASK           30'h0000_0f1f
`define RT_RESET          12'h000
`define RT_BNC_A_SRC      5'h05
`define EVENT_LINES       32

// ==========================================================================
// pin order inside a channel, index added to the update router offset
`define PIN_UPDATE        0
`define PIN_KEYING        1
`define PIN_RAMP_DIR      2
`define PIN_RAMP_HOLD     3
`define PIN_COUNT         4

// ==========================================================================
// bnc port configuration layout
`define BNC_CFG_W         10
`define BNC_DIR_BIT       9
`define BNC_INV_BIT       8
`define BNC_MUX_HI        6
`define BNC_MUX_LO        0
`define BNC_MASK          30'h0000_037f
`define BNC_RESET         10'h000
`define BNC_SRC_LINES     128
`define BNC_PORTS         2
`define BNC_OWNER_CH      0

`endif

// >>> inc/dds_router_pkg.sv
// types and the write-access helper shared by the pin router modules
`include "dds_router_defs.svh"

package dds_router_pkg;

  // ========================================================================
  // register write request from one command processor
  typedef struct packed
  {
    logic                     valid;
    logic [`REG_ADDR_W-1:0]   addr;
    logic [`REG_DATA_W-1:0]   data;
  } reg_write_type;

  // codes follow declaration order: 000 direct .. 100 or
  typedef enum logic [2:0]
  {
    MODE_DIRECT,
    MODE_FORCE_LOW,
    MODE_SELECT,
    MODE_AND,
    MODE_OR
  } routing_mode_type;

  // ========================================================================
  // write, set, clear or toggle on the low payload bits
  function automatic logic [`PAYLOAD_W-1:0] apply_write
  (
    input logic [`PAYLOAD_W-1:0] old_value,
    input logic [`REG_DATA_W-1:0] wr_data,
    input logic [`PAYLOAD_W-1:0] keep_mask
  );
    logic [`PAYLOAD_W-1:0] payload;
    logic [`PAYLOAD_W-1:0] result;
    payload = wr_data[`PAYLOAD_W-1:0];
    unique case (wr_data[`WAM_HI:`WAM_LO])
      `WAM_WRITE:  result = payload;
      `WAM_SET:    result = old_value | payload;
      `WAM_CLEAR:  result = old_value & ~payload;
      `WAM_TOGGLE: result = old_value ^ payload;
    endcase
    // unused bits are kept at zero whatever the writer sent
    return result & keep_mask;
  endfunction

endpackage

// >>> logic/level_sync.sv
// two-stage synchroniser for levels arriving from pins
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             ce_in,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // the first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else if (ce_in)
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> logic/bnc_port_cell.sv
// one shared front-panel bnc port: configuration register, direction and inversion
`timescale 1ns/1ps
`default_nettype none
`include "dds_router_defs.svh"

module bnc_port_cell
  import dds_router_pkg::*;
#(
  parameter logic [`REG_ADDR_W-1:0] CFG_ADDR = `ADDR_BNC_B
)
(
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        reset_n_in,
  input  wire logic                        ce_in,
  // writes from the owning command processor only
  input  wire dds_router_pkg::reg_write_type wr_in,
  // output sources and synchronised pin level
  input  wire logic [`BNC_SRC_LINES-1:0]   source_in,
  input  wire logic                        pin_level_in,
  // pin and conditioned input level
  output var  logic                        pin_out,
  output var  logic                        pin_oe_n_out,
  output var  logic                        level_out
);

  logic [`BNC_CFG_W-1:0] cfg_q;
  logic [`PAYLOAD_W-1:0] cfg_next;

  assign cfg_next = apply_write({{(`PAYLOAD_W-`BNC_CFG_W){1'b0}}, cfg_q}, wr_in.data,
                                `BNC_MASK);

  // ========================================================================
  // configuration register
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cfg_q <= `BNC_RESET;
    else if (ce_in && wr_in.valid && (wr_in.addr == CFG_ADDR))
      cfg_q <= cfg_next[`BNC_CFG_W-1:0];
  end

  // ========================================================================
  // pin drive and input level, inversion on both paths
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_out      <= 1'b0;
      pin_oe_n_out <= 1'b1;
      level_out    <= 1'b0;
    end
    else if (ce_in)
    begin
      pin_out      <= source_in[cfg_q[`BNC_MUX_HI:`BNC_MUX_LO]] ^ cfg_q[`BNC_INV_BIT];
      pin_oe_n_out <= ~cfg_q[`BNC_DIR_BIT];
      level_out    <= pin_level_in ^ cfg_q[`BNC_INV_BIT];
    end
  end

endmodule

`default_nettype wire

// >>> tb/dds_control_pin_router_sva.sv
// assertions on the routed control pins of the pin router
`timescale 1ns/1ps
`default_nettype none
`include "dds_router_defs.svh"

module dds_control_pin_router_sva
  import dds_router_pkg::*;
#(
  parameter int NUM_CH = 2
)
(
  // ==========================================================
  // watched ports
  input  wire logic                                   clk_in,
  input  wire logic                                   reset_n_in,
  input  wire logic                                   ce_in,
  input  wire dds_router_pkg::reg_write_type [NUM_CH-1:0] wr_in,
  input  wire logic [NUM_CH-1:0][`PIN_COUNT-1:0]      dcp_pin_in,
  input  wire logic [`EVENT_LINES-1:0]                event_bus_in,
  input  wire logic                                   bnc_a_level_in,
  input  wire logic [`BNC_PORTS-1:0]                  bnc_pin_oe_n_out,
  input  wire logic [NUM_CH-1:0][`PIN_COUNT-1:0]      dds_pin_out
);
  // ==========================================================
  // shadow of channel zero keying routing
  logic [11:0] cfg_q;
  logic [11:0] p;
  logic [2:0]  md;
  logic        s;
  logic        d;
  logic        x;
  logic        o;
  logic        w0b;
  assign p = wr_in[0].data[11:0] & 12'h0f1f;
  assign o = dds_pin_out[0][1];
  assign w0b = ce_in && wr_in[0].valid && wr_in[0].addr inside {`ADDR_BNC_B, `ADDR_BNC_C};
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
      cfg_q <= 12'h000;
    else if (ce_in && wr_in[0].valid && wr_in[0].addr == `ADDR_KEYING_ROUTE)
      case (wr_in[0].data[31:30])
        2'h0: cfg_q <= p;
        2'h1: cfg_q <= cfg_q | p;
        2'h2: cfg_q <= cfg_q & ~p;
        default: cfg_q <= cfg_q ^ p;
      endcase
  // selector 5 reads bnc a rather than event line 5
  always_comb
  begin
    md = cfg_q[11:9];
    d = dcp_pin_in[0][1];
    s = (cfg_q[4:0] == 5'h05 ? bnc_a_level_in : event_bus_in[cfg_q[4:0]]) ^ cfg_q[8];
    case (md)
      3'h1: x = cfg_q[8];
      3'h2: x = s;
      3'h3: x = d & s;
      3'h4: x = d | s;
      default: x = d ^ cfg_q[8];
    endcase
  end
  // ==========================================================
  // assertions
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_mode_direct: assert property (ce_in && md == 3'h0 |=> o == $past(x))
    else $error("keying pin not direct");
  a_mode_low: assert property (ce_in && md == 3'h1 |=> o == $past(cfg_q[8]))
    else $error("keying pin not forced");
  a_mode_select: assert property (ce_in && md == 3'h2 |=> o == $past(s))
    else $error("keying pin not selector");
  a_mode_and: assert property (ce_in && md == 3'h3 |=> o == $past(d & s))
    else $error("keying pin not and");
  a_mode_or: assert property (ce_in && md == 3'h4 |=> o == $past(d | s))
    else $error("keying pin not or");
  a_mode_reserved: assert property (ce_in && md > 3'h4 |=> o == $past(x))
    else $error("reserved mode not direct");
  a_ce_freeze: assert property (!ce_in |=> $stable(dds_pin_out))
    else $error("pins moved while disabled");
  a_oe_needs_write: assert property ($changed(bnc_pin_oe_n_out) |->
    $past(w0b) || $past(w0b, 2) || $past(w0b, 3))
    else $error("bnc direction moved without owner write");
endmodule
`default_nettype wire

// >>> tb/dds_chip_model.sv
// synthesis chip side: watches the routed pins for update edges
`timescale 1ns/1ps
`default_nettype none

module dds_chip_model #(
  parameter int NUM_CH = 2
)
(
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  // routed pins
  input  wire logic [NUM_CH-1:0][3:0] pins_in,
  output var  logic [NUM_CH-1:0]      update_seen_out
);
  logic [NUM_CH-1:0] prev_q;
  // a router keeping the processor off this pin leaves serial writes unapplied
  always_ff @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      prev_q <= '0;
      update_seen_out <= '0;
    end
    else
      for (int c = 0; c < NUM_CH; c++)
      begin
        prev_q[c] <= pins_in[c][0];
        if (pins_in[c][0] && !prev_q[c])
          update_seen_out[c] <= 1'b1;
      end
endmodule
`default_nettype wire

// >>> tb/dds_control_pin_router_tb.sv
// self-checking bench for the control pin router
`timescale 1ns/1ps
`default_nettype none
`include "dds_router_defs.svh"

module dds_control_pin_router_tb;
  import dds_router_pkg::*;
  logic                clk_in = 1'b0;
  logic                reset_n_in = 1'b0;
  logic                ce_in = 1'b1;
  reg_write_type [1:0] wr_in = '0;
  logic [1:0][3:0]     dcp_pin_in = '0;
  logic [31:0]         event_bus_in = '0;
  logic                bnc_a_level_in = 1'b0;
  logic [127:0]        bnc_source_in = '0;
  logic [1:0]          bnc_pin_in = '0;
  logic [1:0]          bnc_pin_out;
  logic [1:0]          bnc_pin_oe_n_out;
  logic [1:0]          bnc_level_out;
  logic [1:0][3:0]     dds_pin_out;
  logic [1:0]          upd_seen;
  int                  n_errors = 0;
  int                  n_checks = 0;
  always #4 clk_in = ~clk_in;
  dds_control_pin_router #(.NUM_CH(2)) dut (.clk_in, .reset_n_in, .ce_in, .wr_in,
    .dcp_pin_in, .event_bus_in, .bnc_a_level_in, .bnc_source_in, .bnc_pin_in,
    .bnc_pin_out, .bnc_pin_oe_n_out, .bnc_level_out, .dds_pin_out);
  dds_chip_model #(.NUM_CH(2)) chip (.clk_in, .reset_n_in, .pins_in(dds_pin_out),
    .update_seen_out(upd_seen));
  // ==========================================================
  // access tasks
  task automatic wr(input int c, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_in);
    wr_in[c] <= '{valid: 1'b1, addr: a, data: v};
    @(posedge clk_in);
    wr_in[c].valid <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic rp(input logic [2:0] m, input logic i, input logic d, input logic e);
    case (m)
      3'h1: return i;
      3'h2: return e ^ i;
      3'h3: return d & (e ^ i);
      3'h4: return d | (e ^ i);
      default: return d ^ i;
    endcase
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial
  begin
    wt(9);
    check("reset pins", dds_pin_out, 8'h00);
    check("reset oe", 8'(bnc_pin_oe_n_out), 8'h03);
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    dcp_pin_in <= 8'ha5;
    wt(3);
    check("direct", dds_pin_out, 8'ha5);
    for (int k = 0; k < 4; k++)
    begin
      wr(0, `ADDR_UPDATE_ROUTE + 12'(k), 32'h0000_0200);
      dcp_pin_in <= 8'hff;
      wt(2);
      check("pin low", dds_pin_out, 8'hff & ~(8'h01 << k));
      wr(0, `ADDR_UPDATE_ROUTE + 12'(k), 32'h0000_0000);
    end
    wr(1, `ADDR_KEYING_ROUTE, 32'h0000_0200);
    wt(2);
    check("own copy", dds_pin_out, 8'hdf);
    check("update seen", 8'(upd_seen), 8'h03);
    wr(1, `ADDR_KEYING_ROUTE, 32'h0000_0000);
    for (int k = 0; k < 64; k++)
    begin
      wr(0, `ADDR_KEYING_ROUTE, {20'h0, 3'(k >> 3), k[2], 8'h03});
      dcp_pin_in[0][1] <= k[1];
      event_bus_in[3] <= k[0];
      wt(2);
      check("mode", 8'(dds_pin_out[0][1]), 8'(rp(3'(k >> 3), k[2], k[1], k[0])));
    end
    wr(0, `ADDR_KEYING_ROUTE, 32'h0000_0405);
    bnc_a_level_in <= 1'b1;
    event_bus_in <= 32'h8000_0000;
    wt(2);
    check("sel bnc a", 8'(dds_pin_out[0][1]), 8'h01);
    wr(0, `ADDR_KEYING_ROUTE, 32'h0000_041f);
    bnc_a_level_in <= 1'b0;
    wt(2);
    check("sel 31", 8'(dds_pin_out[0][1]), 8'h01);
    wr(0, `ADDR_KEYING_ROUTE, 32'hc000_0100);
    wt(2);
    check("toggle", 8'(dds_pin_out[0][1]), 8'h00);
    wr(0, `ADDR_KEYING_ROUTE, 32'h8000_0100);
    wr(0, `ADDR_KEYING_ROUTE, 32'h4000_0200);
    dcp_pin_in[0][1] <= 1'b0;
    wt(2);
    check("clear set", 8'(dds_pin_out[0][1]), 8'h00);
    @(posedge clk_in);
    ce_in <= 1'b0;
    dcp_pin_in[0][1] <= 1'b1;
    wr(0, `ADDR_KEYING_ROUTE, 32'h0000_0200);
    wt(1);
    check("frozen", 8'(dds_pin_out[0][1]), 8'h00);
    @(posedge clk_in);
    ce_in <= 1'b1;
    wt(2);
    check("ce drop", 8'(dds_pin_out[0][1]), 8'h01);
    wr(1, `ADDR_BNC_B, 32'h0000_0200);
    wr(0, 12'h083, 32'h0000_0200);
    wt(3);
    check("bnc refused", 8'(bnc_pin_oe_n_out), 8'h03);
    wr(0, `ADDR_BNC_B, 32'h0000_0207);
    // source line 7 high and pin b high; only the mux index shows here, the input path shows in the inversion check
    bnc_source_in <= 128'h80;
    bnc_pin_in <= 2'b01;
    wt(3);
    check("bnc out", 8'({bnc_pin_oe_n_out, bnc_pin_out}), 8'h09);
    wr(0, `ADDR_BNC_B, 32'hc000_0100);
    wr(0, `ADDR_BNC_C, 32'h0000_0100);
    wt(4);
    check("bnc inv", 8'({bnc_level_out, bnc_pin_oe_n_out, bnc_pin_out}), 8'h2a);
    complete_run();
  end
  initial
  begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    complete_run();
  end
endmodule

bind dds_control_pin_router dds_control_pin_router_sva #(.NUM_CH(NUM_CH)) chk (.clk_in,
  .reset_n_in, .ce_in, .wr_in, .dcp_pin_in, .event_bus_in, .bnc_a_level_in,
  .bnc_pin_oe_n_out, .dds_pin_out);
`default_nettype wire
